/* File: dv/dcd_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcd_fetch_model
  import dcd_pkg::*;
(
  // clock
  input  wire logic             aclk,
  // fetch handshake
  input  wire logic             instr_ready,
  output logic                  instr_valid,
  output logic [DCD_WORD_W-1:0] instr_word,
  output logic                  cond_met
);
  initial
  begin
    instr_valid = 1'b0;
    instr_word = 16'h0;
    cond_met = 1'b0;
  end
  // word and condition stay put until the edge that takes them
  task automatic send(input logic [15:0] w, input logic c, input logic gap);
    if (gap)
      @(posedge aclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    cond_met <= c;
    do
      @(posedge aclk);
    while (instr_ready !== 1'b1);
  endtask
  // released lines show the inverse of the last value
  task automatic stop();
    instr_valid <= 1'b0;
    instr_word <= ~instr_word;
    cond_met <= ~cond_met;
  endtask
endmodule // dcd_fetch_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dcd_pkg::*;
;
  logic                  aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic                  s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready, instr_valid;
  logic                  instr_ready, cond_met, dec_valid, dec_illegal;
  logic [DCD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DCD_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rs;
  logic [DCD_WORD_W-1:0] instr_word, dec_word, dec_const;
  logic [AUX_SEL_W-1:0]  dec_aux_sel;
  logic [SHIFT_W-1:0]    dec_shift;
  logic [2:0]            dec_cycles;
  dcd_op_t               dec_op;
  logic [15:0]           tw[$];
  dcd_op_t               tp[$];
  logic [3:0]            tk[$];
  int                    fails = 0;
  int                    cmp_count = 0;
  int                    ill_n = 0;

  dcd_decoder DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .instr_valid, .instr_word,
    .instr_ready, .cond_met, .dec_valid, .dec_op, .dec_word, .dec_const,
    .dec_aux_sel, .dec_shift, .dec_cycles, .dec_illegal
  );
  dcd_fetch_model u_fetch (
    .aclk, .instr_ready, .instr_valid, .instr_word, .cond_met
  );

  initial
  begin
    aclk = 1'b0;
    forever
      #25 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test();
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one register access; valids drop at the edge that takes them
  task automatic axi(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    forever
    begin
      @(posedge aclk);
      if (wr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1)
        break;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    rs = wr ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic xchk(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, input logic [31:0] xd,
                      input logic [1:0] xr);
    axi(wr, a, d);
    if (!wr)
      chk("rdata", rd, xd);
    chk("resp", 32'(rs), 32'(xr));
  endtask
  // k: bit 3 two-word, bits 2:0 cycle count
  task automatic run(input logic [15:0] w, input dcd_op_t op,
                     input logic [3:0] k, input logic c);
    int n;
    u_fetch.send(w, c, 1'b1);
    if (k[3])
      u_fetch.send(16'hef00, c, 1'b0);
    u_fetch.stop();
    #1;
    for (n = 0; n < 8 && dec_valid !== 1'b1; n++)
      @(posedge aclk) #1;
    chk("valid", 32'(dec_valid), 32'h1);
    chk("op", 32'(dec_op), 32'(op));
    chk("word", 32'(dec_word), 32'(w));
    chk("const", 32'(dec_const), k[3] ? 32'hef00 : 32'h0);
    chk("cycles", 32'(dec_cycles), 32'(k[2:0]));
    chk("illegal", 32'(dec_illegal), 32'(op == op_illegal));
    chk("aux", 32'(dec_aux_sel), 32'(w[2:0]));
    chk("shift", 32'(dec_shift), 32'(w[11:8]));
    for (n = 0; n < 8 && instr_ready !== 1'b1; n++)
      @(posedge aclk) #1;
    chk("stall", 32'(n), 32'(k[2:0]) - (k[3] ? 32'h2 : 32'h1));
    if (op == op_illegal)
      ill_n++;
  endtask

  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    tw = '{16'h7405, 16'ha212, 16'ha312, 16'h8b8b, 16'h8b12, 16'h5412,
      16'hc123, 16'h5012, 16'h5112, 16'h5512, 16'ha012, 16'hbe02, 16'h8b00,
      16'hbe82, 16'hbfc3, 16'hbe03, 16'hbe05, 16'hbe32, 16'hbe3c, 16'h8a12,
      16'h7612, 16'hef00, 16'hbb05, 16'h0b12, 16'h9d12, 16'h9512, 16'hbf12,
      16'h5312, 16'h5212, 16'h8e12, 16'h8f12, 16'h8d12, 16'h8c12, 16'hae12,
      16'h3712, 16'h6512, 16'hba05, 16'h7c05, 16'h7712, 16'h6f12, 16'hbfa4};
    tk = '{4'h1, 4'hb, 4'hb, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1,
      4'h1, 4'h1, 4'ha, 4'ha, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h4, 4'h1,
      4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'ha, 4'h1,
      4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'ha};
    tp = '{op_load_t_subtract_product,
      op_multiply_accumulate_const, op_multiply_accumulate_move,
      op_load_aux_pointer, op_modify_aux_pointer,
      op_multiply_by_t, op_multiply_immediate,
      op_multiply_add_prev,
      op_multiply_sub_prev, op_multiply_unsigned,
      op_normalize_acc, op_negate_acc, op_no_operation,
      op_or_const_high, op_or_const_shift,
      op_product_to_acc, op_subtract_product,
      op_pop_to_acc, op_push_from_acc,
      op_stack_to_memory, op_memory_to_stack,
      op_subroutine_return,
      op_repeat_imm, op_repeat_mem,
      op_store_high_acc, op_store_low_acc,
      op_product_shift_select, op_square_subtract,
      op_square_add, op_store_status_word_zero,
      op_store_status_word_one, op_store_product_high,
      op_store_product_low, op_store_long_constant,
      op_subtract_shifted, op_subtract_high,
      op_subtract_short_imm, op_aux_subtract_immediate,
      op_illegal, op_illegal, op_subtract_long_imm};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    xchk(1'b0, REG_CTRL, 32'h0, 32'h1, RESP_OKAY);
    xchk(1'b0, REG_STATUS, 32'h0, 32'h0, RESP_OKAY);
    xchk(1'b0, REG_ILLCNT, 32'h0, 32'h0, RESP_OKAY);
    xchk(1'b1, 4'h6, 32'h1, 32'h0, RESP_SLVERR);
    xchk(1'b0, 4'h6, 32'h0, 32'h0, RESP_SLVERR);
    xchk(1'b1, REG_LAST, 32'hffff_ffff, 32'h0, RESP_OKAY);
    xchk(1'b0, REG_LAST, 32'h0, 32'h0, RESP_OKAY);
    xchk(1'b1, REG_CTRL, 32'h0, 32'h0, RESP_OKAY);
    #1;
    chk("ready_off", 32'(instr_ready), 32'h0);
    xchk(1'b1, REG_CTRL, 32'h1, 32'h0, RESP_OKAY);
    for (int i = 0; i < 16; i++)
      run(16'hbe40 | 16'(i), (i % 2 == 1 && i != 9) ? op_set_status_bit :
          op_illegal, 4'h1, 1'b0);
    run(16'hed12, op_conditional_return, 4'h4, 1'b1);
    run(16'hed12, op_conditional_return, 4'h2, 1'b0);
    foreach (tw[j])
      run(tw[j], tp[j], tk[j], 1'b0);
    xchk(1'b0, REG_LAST, 32'h0, 32'hef00_bfa4, RESP_OKAY);
    xchk(1'b0, REG_STATUS, 32'h0, {18'h0, op_subtract_long_imm, 8'h2},
         RESP_OKAY);
    xchk(1'b0, REG_ILLCNT, 32'h0, 32'(ill_n), RESP_OKAY);
    xchk(1'b1, REG_STATUS, 32'h2, 32'h0, RESP_OKAY);
    xchk(1'b0, REG_STATUS, 32'h0, {18'h0, op_subtract_long_imm, 8'h0},
         RESP_OKAY);
    // illegal word in the very cycle of a clear: flag and count keep it
    fork
      xchk(1'b1, REG_STATUS, 32'h2, 32'h0, RESP_OKAY);
      begin
        @(posedge aclk);
        run(16'hbe40, op_illegal, 4'h1, 1'b0);
      end
    join
    xchk(1'b0, REG_STATUS, 32'h0, {18'h0, op_illegal, 8'h2},
         RESP_OKAY);
    fork
      xchk(1'b1, REG_ILLCNT, 32'h0, 32'h0, RESP_OKAY);
      begin
        @(posedge aclk);
        run(16'hbe40, op_illegal, 4'h1, 1'b0);
      end
    join
    xchk(1'b0, REG_ILLCNT, 32'h0, 32'h1, RESP_OKAY);
    xchk(1'b1, REG_ILLCNT, 32'h0, 32'h0, RESP_OKAY);
    xchk(1'b0, REG_ILLCNT, 32'h0, 32'h0, RESP_OKAY);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

/* File: hdl/dcd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module dcd_decoder
  import dcd_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire logic [DCD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DCD_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [DCD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DCD_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // instruction words from fetch
  input  wire logic                  instr_valid,
  input  wire logic [DCD_WORD_W-1:0] instr_word,
  output logic                       instr_ready,
  input  wire logic                  cond_met,
  // decoded instruction
  output logic                       dec_valid,
  output var dcd_op_t                dec_op,
  output logic [DCD_WORD_W-1:0]      dec_word,
  output logic [DCD_WORD_W-1:0]      dec_const,
  output logic [AUX_SEL_W-1:0]       dec_aux_sel,
  output logic [SHIFT_W-1:0]         dec_shift,
  output logic [2:0]                 dec_cycles,
  output logic                       dec_illegal
);

  dcd_state_t            state_ff, nxt_state;
  logic [2:0]            stall_cnt_ff, nxt_cnt;
  dcd_op_t               op_c, op_hold_ff, fire_op;
  logic                  two_word_c;
  logic [2:0]            cycles_c, cyc_hold_ff, fire_cyc;
  logic [DCD_WORD_W-1:0] word_hold_ff, fire_word, fire_const;
  logic                  fire, accept, issuing;
  logic                  ctrl_en_ff, ill_seen_ff, nxt_ill_seen;
  logic [15:0]           ill_cnt_ff, nxt_ill_cnt;
  logic                  ill_event;

  // opcode table, first match wins
  always_comb
  begin
    op_c = op_illegal;
    two_word_c = 1'b0;
    cycles_c = CYC_ONE;
    casez (instr_word)
      16'h74??: op_c = op_load_t_subtract_product;
      16'ha2??:
      begin
        op_c = op_multiply_accumulate_const;
        two_word_c = 1'b1;
        cycles_c = CYC_THREE;
      end
      16'ha3??:
      begin
        op_c = op_multiply_accumulate_move;
        two_word_c = 1'b1;
        cycles_c = CYC_THREE;
      end
      OPC_NO_OPERATION: op_c = op_no_operation;
      16'b1000_1011_1000_1???: op_c = op_load_aux_pointer;
      16'h8b??: op_c = op_modify_aux_pointer;
      16'h54??: op_c = op_multiply_by_t;
      16'b110?_????_????_????: op_c = op_multiply_immediate;
      16'h50??: op_c = op_multiply_add_prev;
      16'h51??: op_c = op_multiply_sub_prev;
      16'h55??: op_c = op_multiply_unsigned;
      16'ha0??: op_c = op_normalize_acc;
      16'hbe02: op_c = op_negate_acc;
      16'hbe82:
      begin
        op_c = op_or_const_high;
        two_word_c = 1'b1;
        cycles_c = CYC_TWO;
      end
      16'hbfc?:
      begin
        op_c = op_or_const_shift;
        two_word_c = 1'b1;
        cycles_c = CYC_TWO;
      end
      16'hbfa?:
      begin
        op_c = op_subtract_long_imm;
        two_word_c = 1'b1;
        cycles_c = CYC_TWO;
      end
      16'hbf??: op_c = op_product_shift_select;
      16'hbe03: op_c = op_product_to_acc;
      16'hbe05: op_c = op_subtract_product;
      16'hbe32: op_c = op_pop_to_acc;
      16'hbe3c: op_c = op_push_from_acc;
      16'h8a??: op_c = op_stack_to_memory;
      16'h76??: op_c = op_memory_to_stack;
      OPC_RETURN:
      begin
        op_c = op_subroutine_return;
        cycles_c = CYC_FOUR;
      end
      16'b1110_11??_????_????:
      begin
        op_c = op_conditional_return;
        cycles_c = cond_met ? CYC_FOUR : CYC_TWO;
      end
      16'hbb??: op_c = op_repeat_imm;
      16'h0b??: op_c = op_repeat_mem;
      16'b1001_1???_????_????: op_c = op_store_high_acc;
      16'b1001_0???_????_????: op_c = op_store_low_acc;
      16'hbe4f, 16'hbe45, 16'hbe41, 16'hbe43,
      16'hbe4b, 16'hbe4d, 16'hbe47: op_c = op_set_status_bit;
      16'h53??: op_c = op_square_subtract;
      16'h52??: op_c = op_square_add;
      16'h8e??: op_c = op_store_status_word_zero;
      16'h8f??: op_c = op_store_status_word_one;
      16'h8d??: op_c = op_store_product_high;
      16'h8c??: op_c = op_store_product_low;
      16'hae??:
      begin
        op_c = op_store_long_constant;
        two_word_c = 1'b1;
        cycles_c = CYC_TWO;
      end
      16'h3???: op_c = op_subtract_shifted;
      16'h65??: op_c = op_subtract_high;
      16'hba??: op_c = op_subtract_short_imm;
      16'h7c??: op_c = op_aux_subtract_immediate;
      default: op_c = op_illegal;
    endcase
  end

  // instruction handshake
  assign issuing = (state_ff == st_issue);
  assign instr_ready = (issuing && ctrl_en_ff) || (state_ff == st_operand);
  assign accept = instr_valid && instr_ready;
  assign fire_op = issuing ? op_c : op_hold_ff;
  assign fire_cyc = issuing ? cycles_c : cyc_hold_ff;
  assign fire_word = issuing ? instr_word : word_hold_ff;
  assign fire_const = issuing ? '0 : instr_word;
  assign ill_event = fire && (fire_op == op_illegal);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = stall_cnt_ff;
    fire = 1'b0;
    case (state_ff)
      st_issue:
        if (accept)
        begin
          if (two_word_c)
            nxt_state = st_operand;
          else
          begin
            fire = 1'b1;
            if (cycles_c != CYC_ONE)
            begin
              nxt_state = st_stall;
              nxt_cnt = cycles_c - CYC_ONE;
            end
          end
        end
      st_operand:
        if (accept)
        begin
          // second word taken as constant, never decoded
          fire = 1'b1;
          if (cyc_hold_ff != CYC_TWO)
          begin
            nxt_state = st_stall;
            nxt_cnt = cyc_hold_ff - CYC_TWO;
          end
          else
            nxt_state = st_issue;
        end
      st_stall:
      begin
        nxt_cnt = stall_cnt_ff - CYC_ONE;
        if (stall_cnt_ff == CYC_ONE)
          nxt_state = st_issue;
      end
      default: nxt_state = st_issue;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= st_issue;
      stall_cnt_ff <= '0;
      op_hold_ff <= op_illegal;
      cyc_hold_ff <= CYC_ONE;
      word_hold_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      stall_cnt_ff <= nxt_cnt;
      if (issuing && accept)
      begin
        op_hold_ff <= op_c;
        cyc_hold_ff <= cycles_c;
        word_hold_ff <= instr_word;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dec_valid <= 1'b0;
      dec_op <= op_illegal;
      dec_word <= '0;
      dec_const <= '0;
      dec_aux_sel <= '0;
      dec_shift <= '0;
      dec_cycles <= '0;
      dec_illegal <= 1'b0;
    end
    else
    begin
      dec_valid <= fire;
      if (fire)
      begin
        dec_op <= fire_op;
        dec_word <= fire_word;
        dec_const <= fire_const;
        dec_aux_sel <= fire_word[AUX_SEL_LSB +: AUX_SEL_W];
        dec_shift <= fire_word[SHIFT_LSB +: SHIFT_W];
        dec_cycles <= fire_cyc;
        dec_illegal <= (fire_op == op_illegal);
      end
    end
  end

  // axi4-lite slave
  logic                  aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [DCD_ADDR_W-1:0] awaddr_ff;
  logic [DCD_DATA_W-1:0] wdata_ff, rdata_ff, rd_mux;
  logic [3:0]            wstrb_ff;
  logic [1:0]            bresp_ff, rresp_ff;
  wire                   wr_do, wr_ctrl, wr_status, wr_last, wr_cnt;
  wire                   wr_map, rd_map, ar_fire, ill_clear;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_ctrl = wr_do && (awaddr_ff == REG_CTRL);
  assign wr_status = wr_do && (awaddr_ff == REG_STATUS);
  assign wr_last = wr_do && (awaddr_ff == REG_LAST);
  assign wr_cnt = wr_do && (awaddr_ff == REG_ILLCNT);
  assign wr_map = wr_ctrl || wr_status || wr_last || wr_cnt;
  assign ill_clear = wr_status && wstrb_ff[0] && wdata_ff[STAT_ILL_BIT];
  assign ar_fire = s_axi_arvalid && !rvalid_ff;
  assign rd_map = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS)
               || (s_axi_araddr == REG_LAST) || (s_axi_araddr == REG_ILLCNT);

  always_comb
  begin
    rd_mux = '0;
    case (s_axi_araddr)
      REG_CTRL: rd_mux[CTRL_EN_BIT] = ctrl_en_ff;
      REG_STATUS:
      begin
        rd_mux[STAT_BUSY_BIT] = !issuing;
        rd_mux[STAT_ILL_BIT] = ill_seen_ff;
        rd_mux[STAT_OP_LSB +: STAT_OP_W] = dec_op;
      end
      REG_LAST:
      begin
        rd_mux[DCD_WORD_W-1:0] = dec_word;
        rd_mux[LAST_CONST_LSB +: DCD_WORD_W] = dec_const;
      end
      REG_ILLCNT: rd_mux[15:0] = ill_cnt_ff;
      default: rd_mux = '0;
    endcase
  end

  // sticky flag and count: a new illegal word beats a clear
  assign nxt_ill_seen = ill_event || (ill_seen_ff && !ill_clear);
  assign nxt_ill_cnt = wr_cnt ? {15'h0000, ill_event}
                     : (ill_event && (ill_cnt_ff != 16'hffff))
                       ? ill_cnt_ff + 16'h0001 : ill_cnt_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_en_ff <= CTRL_EN_RESET;
      ill_seen_ff <= 1'b0;
      ill_cnt_ff <= '0;
    end
    else
    begin
      if (wr_ctrl && wstrb_ff[0])
        ctrl_en_ff <= wdata_ff[CTRL_EN_BIT];
      ill_seen_ff <= nxt_ill_seen;
      ill_cnt_ff <= nxt_ill_cnt;
    end
  end

  // checks
  property p_return_stall;
    @(posedge aclk) disable iff (!aresetn)
    (issuing && accept && op_c == op_subroutine_return)
      |=> (!instr_ready)[*3] ##1 (state_ff == st_issue);
  endproperty
  a_return_stall: assert property (p_return_stall)
    else $error("return did not stall three cycles");

  property p_cond_return_skip;
    @(posedge aclk) disable iff (!aresetn)
    (issuing && accept && op_c == op_conditional_return && !cond_met)
      |=> !instr_ready ##1 (state_ff == st_issue);
  endproperty
  a_cond_return_skip: assert property (p_cond_return_skip)
    else $error("untaken conditional return not two cycles");

  property p_mul_acc_three;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == st_operand && accept
      && op_hold_ff == op_multiply_accumulate_const)
      |=> dec_valid && !instr_ready ##1 (state_ff == st_issue);
  endproperty
  a_mul_acc_three: assert property (p_mul_acc_three)
    else $error("multiply-accumulate not three cycles");

  property p_second_word;
    @(posedge aclk) disable iff (!aresetn)
    (issuing && accept && two_word_c)
      |=> (state_ff == st_operand) && !dec_valid;
  endproperty
  a_second_word: assert property (p_second_word)
    else $error("second word not awaited as operand");

  property p_illegal;
    @(posedge aclk) disable iff (!aresetn)
    (issuing && accept && op_c == op_illegal)
      |=> dec_valid && dec_illegal && (state_ff == st_issue);
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("unmatched word not flagged");

  property p_no_op;
    @(posedge aclk) disable iff (!aresetn)
    (issuing && accept && instr_word == OPC_NO_OPERATION)
      |=> dec_valid && dec_op == op_no_operation && dec_cycles == CYC_ONE;
  endproperty
  a_no_op: assert property (p_no_op)
    else $error("no-operation word misdecoded");

  property p_aux_sel;
    @(posedge aclk) disable iff (!aresetn)
    (issuing && accept && op_c == op_load_aux_pointer)
      |=> dec_aux_sel == $past(instr_word[AUX_SEL_W-1:0]);
  endproperty
  a_aux_sel: assert property (p_aux_sel)
    else $error("aux select field lost");

  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (ill_event && ill_clear) |=> ill_seen_ff ##1 ill_seen_ff;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("illegal flag lost against clear");

endmodule // dcd_decoder
`default_nettype wire

/* File: pkg/dcd_pkg.sv */
`default_nettype none
package dcd_pkg;
  localparam int unsigned DCD_WORD_W = 16;
  localparam int unsigned DCD_ADDR_W = 4;
  localparam int unsigned DCD_DATA_W = 32;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAST = 4'h8;
  localparam logic [3:0] REG_ILLCNT = 4'hc;
  // register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ILL_BIT = 1;
  localparam int unsigned STAT_OP_LSB = 8;
  localparam int unsigned STAT_OP_W = 6;
  localparam int unsigned LAST_CONST_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // instruction fields
  localparam int unsigned AUX_SEL_LSB = 0;
  localparam int unsigned AUX_SEL_W = 3;
  localparam int unsigned SHIFT_LSB = 8;
  localparam int unsigned SHIFT_W = 4;
  localparam int unsigned STORE_SHIFT_W = 3;
  localparam int unsigned STATUS_CODE_W = 4;
  // whole-word encodings
  localparam logic [15:0] OPC_NO_OPERATION = 16'h8b00;
  localparam logic [15:0] OPC_RETURN = 16'hef00;
  // cycle counts
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  typedef enum logic [5:0] {
    op_illegal, op_load_t_subtract_product, op_multiply_accumulate_const,
    op_multiply_accumulate_move, op_load_aux_pointer, op_modify_aux_pointer,
    op_multiply_by_t, op_multiply_immediate, op_multiply_add_prev,
    op_multiply_sub_prev, op_multiply_unsigned, op_normalize_acc,
    op_negate_acc, op_no_operation, op_or_const_high, op_or_const_shift,
    op_product_to_acc, op_subtract_product, op_pop_to_acc, op_push_from_acc,
    op_stack_to_memory, op_memory_to_stack, op_subroutine_return,
    op_conditional_return, op_repeat_imm, op_repeat_mem, op_store_high_acc,
    op_store_low_acc, op_set_status_bit, op_product_shift_select,
    op_square_add, op_square_subtract, op_store_status_word_zero,
    op_store_status_word_one, op_store_product_high, op_store_product_low,
    op_store_long_constant, op_subtract_shifted, op_subtract_high,
    op_subtract_short_imm, op_subtract_long_imm, op_aux_subtract_immediate
  } dcd_op_t;
  typedef enum logic [1:0] {
    st_issue   = 2'h0,
    st_operand = 2'h1,
    st_stall   = 2'h3
  } dcd_state_t;
endpackage
`default_nettype wire
